/* rtl/fcu_pkg.sv */
// Function
// - decode int-to-double, opcode 63/846, record bit
// - signed 64-bit integer rounded to double
// - int-to-double sets class, rounded-up, inexact
// - record bit copies summaries into field 1
// - conversions illegal in 32-bit mode
// - decode compares, opcode 63, xo 32/0
// - compare sets code, copies to selected field
// - any NaN operand gives unordered code
// - signaling NaN sets its invalid flag
// - ordered, signaling NaN, invalid disabled: compare flag
// - ordered compare with quiet NaN: compare flag
// - unordered compare never sets compare flag
// - ordered compare always updates its status bits
// - decode double-to-int, opcode 63/814, record bit
// - double to signed 64-bit using rounding control
// - saturate to max positive or most negative
// - double-to-int leaves class, sets rounded-up, inexact
// - conversions round by the rounding control field
package fcu_pkg;
  localparam logic [5:0]  FCU_OPC_FP        = 6'h3f;
  localparam logic [9:0]  FCU_XO_FROM_INT   = 10'h34e;
  localparam logic [9:0]  FCU_XO_TO_INT     = 10'h32e;
  localparam logic [9:0]  FCU_XO_CMP_ORD    = 10'h020;
  localparam logic [9:0]  FCU_XO_CMP_UNORD  = 10'h000;
  localparam logic [4:0]  FCU_FIELD_ZERO    = 5'h00;
  localparam logic [2:0]  FCU_CR_FIELD_CONV = 3'h1;
  // status/control bit positions (bit 31 is the leftmost bit)
  localparam int FCU_B_FX     = 31;
  localparam int FCU_B_FEX    = 30;
  localparam int FCU_B_VX     = 29;
  localparam int FCU_B_OX     = 28;
  localparam int FCU_B_UX     = 27;
  localparam int FCU_B_ZX     = 26;
  localparam int FCU_B_XX     = 25;
  localparam int FCU_B_SIGNALING_NAN_INVALID = 24;
  localparam int FCU_B_INVALID_COMPARE_FLAG   = 19;
  localparam int FCU_B_FR     = 18;
  localparam int FCU_B_FI     = 17;
  localparam int FCU_B_RESULT_CLASS_FIELD   = 12;
  localparam int FCU_B_INVALID_CONVERT_FLAG  = 8;
  localparam int FCU_B_VE     = 7;
  localparam int FCU_B_OE     = 6;
  localparam int FCU_B_UE     = 5;
  localparam int FCU_B_ZE     = 4;
  localparam int FCU_B_XE     = 3;
  localparam int FCU_B_RN     = 0;
  localparam logic [31:0] FCU_EXC_MASK      = 32'h1ff8_0700;
  localparam logic [31:0] FCU_VX_MASK       = 32'h01f8_0700;
  localparam logic [31:0] FCU_FP_STATUS_CONTROL_REG_RST     = 32'h0000_0000;
  localparam logic [31:0] FCU_CR_RST        = 32'h0000_0000;
  localparam logic [7:0]  FCU_OFS_CTRL      = 8'h00;
  localparam logic [7:0]  FCU_OFS_FP_STATUS_CONTROL_REG     = 8'h04;
  localparam logic [7:0]  FCU_OFS_CR        = 8'h08;
  localparam logic [7:0]  FCU_OFS_IRQ_STAT  = 8'h0c;
  localparam logic [7:0]  FCU_OFS_IRQ_MASK  = 8'h10;
  localparam logic [31:0] FCU_CTRL_RST      = 32'h0000_0001;
  localparam int          FCU_CTRL_MODE64   = 0;
  localparam int          FCU_IRQ_W         = 4;
  localparam int          FCU_IRQ_ILLEGAL   = 0;
  localparam int          FCU_IRQ_VX        = 1;
  localparam int          FCU_IRQ_FEX       = 2;
  localparam int          FCU_IRQ_DONE      = 3;
  localparam logic [1:0]  FCU_RN_NEAR       = 2'h0;
  localparam logic [1:0]  FCU_RN_ZERO       = 2'h1;
  localparam logic [1:0]  FCU_RN_PINF       = 2'h2;
  localparam logic [1:0]  FCU_RN_NINF       = 2'h3;
  localparam logic [4:0]  FCU_RESULT_CLASS_FIELD_PNORM    = 5'h04;
  localparam logic [4:0]  FCU_RESULT_CLASS_FIELD_NNORM    = 5'h08;
  localparam logic [4:0]  FCU_RESULT_CLASS_FIELD_PZERO    = 5'h02;
  localparam logic [3:0]  FCU_CC_LT         = 4'h8;
  localparam logic [3:0]  FCU_CC_GT         = 4'h4;
  localparam logic [3:0]  FCU_CC_EQ         = 4'h2;
  localparam logic [3:0]  FCU_CC_UN         = 4'h1;
  localparam logic [10:0] FCU_EXP_BIAS      = 11'h3ff;
  localparam logic [10:0] FCU_EXP_ALL1      = 11'h7ff;
  localparam logic [10:0] FCU_EXP_INT_TOP   = 11'h43e;
  localparam logic [63:0] FCU_INT_MAX       = 64'h7fff_ffff_ffff_ffff;
  localparam logic [63:0] FCU_INT_MIN       = 64'h8000_0000_0000_0000;
  typedef enum logic [2:0] {
    FCU_OP_NONE      = 3'b000,
    FCU_OP_FROM_INT  = 3'b001,
    FCU_OP_TO_INT    = 3'b010,
    FCU_OP_CMP_ORD   = 3'b011,
    FCU_OP_CMP_UNORD = 3'b100,
    FCU_OP_ILLEGAL   = 3'b101
  } fcu_op_t;
endpackage : fcu_pkg

/* rtl/fcu_unit.sv */
// The register offsets and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module fcu_unit
  import fcu_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        issue_valid,
  input  wire logic [31:0] instr,
  input  wire logic [63:0] first_source_fp_reg,
  input  wire logic [63:0] second_source_fp_reg,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  output logic             res_valid,
  output logic [63:0]      res_data,
  output logic [4:0]       target_fp_reg,
  output logic             cr_we,
  output logic [2:0]       cr_field_select,
  output logic [3:0]       cr_field_data,
  output logic             illegal_instr,
  output logic             irq
);
  function automatic logic [6:0] fcu_lzc64(input logic [63:0] v);
    logic [6:0] n;
    logic       hit;
    n   = 7'd64;
    hit = 1'b0;
    for (int i = 63; i >= 0; i--) begin
      if (!hit && v[i]) begin
        n   = 7'(63 - i);
        hit = 1'b1;
      end
    end
    return n;
  endfunction : fcu_lzc64

  function automatic logic fcu_round_inc(input logic [1:0] rn, input logic sgn,
                                         input logic lsb, input logic g, input logic st);
    case (rn)
      FCU_RN_NEAR: return g & (st | lsb);
      FCU_RN_PINF: return ~sgn & (g | st);
      FCU_RN_NINF: return sgn & (g | st);
      default:     return 1'b0;
    endcase
  endfunction : fcu_round_inc

  function automatic logic fcu_is_nan(input logic [63:0] d);
    return (d[62:52] == FCU_EXP_ALL1) && (d[51:0] != 52'h0);
  endfunction : fcu_is_nan

  function automatic logic fcu_is_snan(input logic [63:0] d);
    return fcu_is_nan(d) && !d[51];
  endfunction : fcu_is_snan

  logic [31:0] ctrl_r;
  logic [31:0] fp_status_control_reg_r;
  logic [31:0] fp_status_control_reg_nxt;
  logic [31:0] cr_r;
  logic [FCU_IRQ_W-1:0] irq_stat_r;
  logic [FCU_IRQ_W-1:0] irq_mask_r;
  logic [FCU_IRQ_W-1:0] irq_ev;
  fcu_op_t     op;
  logic        mode64;
  logic        rec;
  logic [1:0]  rn;
  logic        wr_ctrl;
  logic        wr_fp_status_control_reg;
  logic        wr_cr;
  logic        wr_stat;
  logic        wr_mask;

  assign mode64   = ctrl_r[FCU_CTRL_MODE64];
  assign rec      = instr[0];
  assign rn       = fp_status_control_reg_r[FCU_B_RN +: 2];
  assign wr_ctrl  = reg_wr && (reg_addr == FCU_OFS_CTRL);
  assign wr_fp_status_control_reg = reg_wr && (reg_addr == FCU_OFS_FP_STATUS_CONTROL_REG);
  assign wr_cr    = reg_wr && (reg_addr == FCU_OFS_CR);
  assign wr_stat  = reg_wr && (reg_addr == FCU_OFS_IRQ_STAT);
  assign wr_mask  = reg_wr && (reg_addr == FCU_OFS_IRQ_MASK);

  // reserved compare bits are ignored rather than trapped
  always_comb begin
    op = FCU_OP_NONE;
    if (issue_valid && instr[31:26] == FCU_OPC_FP) begin
      if (instr[10:1] == FCU_XO_FROM_INT && instr[20:16] == FCU_FIELD_ZERO) begin
        op = mode64 ? FCU_OP_FROM_INT : FCU_OP_ILLEGAL;
      end else if (instr[10:1] == FCU_XO_TO_INT && instr[20:16] == FCU_FIELD_ZERO) begin
        op = mode64 ? FCU_OP_TO_INT : FCU_OP_ILLEGAL;
      end else if (instr[10:1] == FCU_XO_CMP_ORD) begin
        op = FCU_OP_CMP_ORD;
      end else if (instr[10:1] == FCU_XO_CMP_UNORD) begin
        op = FCU_OP_CMP_UNORD;
      end
    end
  end

  // integer to double
  logic        ci_sign;
  logic [63:0] ci_mag;
  logic [6:0]  ci_lz;
  logic [63:0] ci_norm;
  logic        ci_g;
  logic        ci_st;
  logic        ci_inc;
  logic [53:0] ci_sum;
  logic [10:0] ci_exp;
  logic [63:0] ci_res;
  logic [4:0]  ci_result_class_field;

  always_comb begin
    ci_sign = second_source_fp_reg[63];
    ci_mag  = ci_sign ? 64'(-second_source_fp_reg) : second_source_fp_reg;
    ci_lz   = fcu_lzc64(ci_mag);
    ci_norm = ci_mag << ci_lz;
    ci_g    = ci_norm[10];
    ci_st   = |ci_norm[9:0];
    ci_inc  = fcu_round_inc(rn, ci_sign, ci_norm[11], ci_g, ci_st);
    ci_sum  = {1'b0, ci_norm[63:11]} + 54'(ci_inc);
    ci_exp  = FCU_EXP_INT_TOP - {4'h0, ci_lz};
    if (ci_sum[53]) begin
      ci_res = {ci_sign, 11'(ci_exp + 11'h001), 52'h0};
    end else begin
      ci_res = {ci_sign, ci_exp, ci_sum[51:0]};
    end
    if (ci_mag == 64'h0) begin
      ci_res  = 64'h0;
      ci_result_class_field = FCU_RESULT_CLASS_FIELD_PZERO;
    end else begin
      ci_result_class_field = ci_sign ? FCU_RESULT_CLASS_FIELD_NNORM : FCU_RESULT_CLASS_FIELD_PNORM;
    end
  end

  // double to integer: fixed point, integer in [127:64], fraction below
  logic         ti_sign;
  logic [10:0]  ti_exp;
  logic [127:0] ti_fix;
  logic         ti_g;
  logic         ti_st;
  logic         ti_inc;
  logic [64:0]  ti_mag;
  logic         ti_nan;
  logic         ti_big;
  logic         ti_min;
  logic         ti_inv;
  logic [63:0]  ti_res;

  always_comb begin
    ti_sign = second_source_fp_reg[63];
    ti_exp  = second_source_fp_reg[62:52];
    ti_nan  = fcu_is_nan(second_source_fp_reg);
    ti_big  = ti_exp >= FCU_EXP_INT_TOP;
    ti_min  = ti_sign && ti_exp == FCU_EXP_INT_TOP && second_source_fp_reg[51:0] == 52'h0;
    ti_fix  = {63'h0, 1'b1, second_source_fp_reg[51:0], 12'h0};
    ti_g    = 1'b0;
    ti_st   = 1'b0;
    if (ti_exp == 11'h000) begin
      ti_fix = 128'h0;
      ti_st  = second_source_fp_reg[51:0] != 52'h0;
    end else if (ti_exp < 11'(FCU_EXP_BIAS - 11'h001)) begin
      ti_fix = 128'h0;
      ti_st  = 1'b1;
    end else if (ti_exp == 11'(FCU_EXP_BIAS - 11'h001)) begin
      ti_fix = ti_fix >> 1;
    end else if (!ti_big) begin
      ti_fix = ti_fix << 6'(ti_exp - FCU_EXP_BIAS);
    end
    if (ti_exp != 11'h000 && !ti_big) begin
      ti_g  = ti_fix[63];
      ti_st = ti_st | (|ti_fix[62:0]);
    end
    ti_inc = fcu_round_inc(rn, ti_sign, ti_fix[64], ti_g, ti_st);
    ti_mag = {1'b0, ti_fix[127:64]} + 65'(ti_inc);
    // rounding up can push an in-range magnitude past the limit
    ti_inv = ti_nan || (ti_big && !ti_min) ||
             (!ti_big && (ti_sign ? (ti_mag > {1'b0, FCU_INT_MIN}) : (ti_mag > {1'b0, FCU_INT_MAX})));
    if (ti_nan || ti_min) begin
      ti_res = FCU_INT_MIN;
    end else if (ti_inv) begin
      ti_res = ti_sign ? FCU_INT_MIN : FCU_INT_MAX;
    end else begin
      ti_res = ti_sign ? 64'(-ti_mag[63:0]) : ti_mag[63:0];
    end
  end

  // compare
  logic       cm_a_nan;
  logic       cm_b_nan;
  logic       cm_snan;
  logic       cm_qnan;
  logic       cm_lt;
  logic       cm_eq;
  logic [3:0] cm_code;

  always_comb begin
    cm_a_nan = fcu_is_nan(first_source_fp_reg);
    cm_b_nan = fcu_is_nan(second_source_fp_reg);
    cm_snan  = fcu_is_snan(first_source_fp_reg) || fcu_is_snan(second_source_fp_reg);
    cm_qnan  = (cm_a_nan && first_source_fp_reg[51]) || (cm_b_nan && second_source_fp_reg[51]);
    cm_eq    = (first_source_fp_reg == second_source_fp_reg) ||
               (first_source_fp_reg[62:0] == 63'h0 && second_source_fp_reg[62:0] == 63'h0);
    if (first_source_fp_reg[63] != second_source_fp_reg[63]) begin
      cm_lt = first_source_fp_reg[63];
    end else if (first_source_fp_reg[63]) begin
      cm_lt = first_source_fp_reg[62:0] > second_source_fp_reg[62:0];
    end else begin
      cm_lt = first_source_fp_reg[62:0] < second_source_fp_reg[62:0];
    end
    if (cm_a_nan || cm_b_nan) begin
      cm_code = FCU_CC_UN;
    end else if (cm_eq) begin
      cm_code = FCU_CC_EQ;
    end else begin
      cm_code = cm_lt ? FCU_CC_LT : FCU_CC_GT;
    end
  end

  // status/control next value; hardware sets win over a same-cycle write
  logic [31:0] f_base;
  logic [31:0] f_new;

  always_comb begin
    f_base = wr_fp_status_control_reg ? reg_wdata : fp_status_control_reg_r;
    f_new  = f_base;
    case (op)
      FCU_OP_FROM_INT: begin
        f_new[FCU_B_RESULT_CLASS_FIELD +: 5] = ci_result_class_field;
        f_new[FCU_B_FR]        = ci_inc;
        f_new[FCU_B_FI]        = ci_g | ci_st;
        f_new[FCU_B_XX]        = f_base[FCU_B_XX] | ci_g | ci_st;
      end
      FCU_OP_TO_INT: begin
        f_new[FCU_B_FR]     = !ti_inv && ti_inc;
        f_new[FCU_B_FI]     = !ti_inv && (ti_g | ti_st);
        f_new[FCU_B_XX]     = f_base[FCU_B_XX] | (!ti_inv && (ti_g | ti_st));
        f_new[FCU_B_SIGNALING_NAN_INVALID] = f_base[FCU_B_SIGNALING_NAN_INVALID] | fcu_is_snan(second_source_fp_reg);
        f_new[FCU_B_INVALID_CONVERT_FLAG]  = f_base[FCU_B_INVALID_CONVERT_FLAG] | ti_inv;
      end
      FCU_OP_CMP_ORD: begin
        f_new[FCU_B_RESULT_CLASS_FIELD +: 4] = cm_code;
        f_new[FCU_B_SIGNALING_NAN_INVALID]    = f_base[FCU_B_SIGNALING_NAN_INVALID] | cm_snan;
        f_new[FCU_B_INVALID_COMPARE_FLAG]      = f_base[FCU_B_INVALID_COMPARE_FLAG] | (cm_snan && !f_base[FCU_B_VE]) | cm_qnan;
      end
      FCU_OP_CMP_UNORD: begin
        f_new[FCU_B_RESULT_CLASS_FIELD +: 4] = cm_code;
        f_new[FCU_B_SIGNALING_NAN_INVALID]    = f_base[FCU_B_SIGNALING_NAN_INVALID] | cm_snan;
      end
      default: begin
      end
    endcase
    f_new[FCU_B_VX]  = |(f_new & FCU_VX_MASK);
    f_new[FCU_B_FX]  = f_base[FCU_B_FX] | (|(f_new & ~f_base & FCU_EXC_MASK));
    f_new[FCU_B_FEX] = (f_new[FCU_B_VX] & f_new[FCU_B_VE]) | (f_new[FCU_B_OX] & f_new[FCU_B_OE]) |
                       (f_new[FCU_B_UX] & f_new[FCU_B_UE]) | (f_new[FCU_B_ZX] & f_new[FCU_B_ZE]) |
                       (f_new[FCU_B_XX] & f_new[FCU_B_XE]);
    fp_status_control_reg_nxt = f_new;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      fp_status_control_reg_r <= FCU_FP_STATUS_CONTROL_REG_RST;
    end else begin
      fp_status_control_reg_r <= fp_status_control_reg_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ctrl_r <= FCU_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_r <= reg_wdata & FCU_CTRL_RST;
    end
  end

  // condition register field write, one field per instruction
  logic       crw_en;
  logic [2:0] crw_sel;
  logic [3:0] crw_val;

  always_comb begin
    crw_en  = 1'b0;
    crw_sel = instr[25:23];
    crw_val = cm_code;
    if (op == FCU_OP_CMP_ORD || op == FCU_OP_CMP_UNORD) begin
      crw_en = 1'b1;
    end else if ((op == FCU_OP_FROM_INT || op == FCU_OP_TO_INT) && rec) begin
      crw_en  = 1'b1;
      crw_sel = FCU_CR_FIELD_CONV;
      crw_val = {fp_status_control_reg_nxt[FCU_B_FX], fp_status_control_reg_nxt[FCU_B_FEX], fp_status_control_reg_nxt[FCU_B_VX], fp_status_control_reg_nxt[FCU_B_OX]};
    end
  end

  // field 0 sits in the top nibble
  generate
    for (genvar g = 0; g < 8; g++) begin : g_cr
      always_ff @(posedge clk) begin
        if (!reset_n) begin
          cr_r[31-4*g -: 4] <= FCU_CR_RST[31-4*g -: 4];
        end else if (crw_en && crw_sel == 3'(g)) begin
          cr_r[31-4*g -: 4] <= crw_val;
        end else if (wr_cr) begin
          cr_r[31-4*g -: 4] <= reg_wdata[31-4*g -: 4];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cr_we           <= 1'b0;
      cr_field_select <= 3'h0;
      cr_field_data   <= 4'h0;
    end else begin
      cr_we           <= crw_en;
      cr_field_select <= crw_sel;
      cr_field_data   <= crw_val;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      res_valid     <= 1'b0;
      res_data      <= 64'h0;
      target_fp_reg <= 5'h00;
      illegal_instr <= 1'b0;
    end else begin
      res_valid     <= op == FCU_OP_FROM_INT || op == FCU_OP_TO_INT;
      res_data      <= (op == FCU_OP_FROM_INT) ? ci_res : ti_res;
      target_fp_reg <= instr[25:21];
      illegal_instr <= op == FCU_OP_ILLEGAL;
    end
  end

  // interrupts: sticky, write one to clear, set wins
  assign irq_ev[FCU_IRQ_ILLEGAL] = op == FCU_OP_ILLEGAL;
  assign irq_ev[FCU_IRQ_VX]      = fp_status_control_reg_nxt[FCU_B_VX] && !fp_status_control_reg_r[FCU_B_VX];
  assign irq_ev[FCU_IRQ_FEX]     = fp_status_control_reg_nxt[FCU_B_FEX] && !fp_status_control_reg_r[FCU_B_FEX];
  assign irq_ev[FCU_IRQ_DONE]    = op != FCU_OP_NONE && op != FCU_OP_ILLEGAL;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      irq_stat_r <= '0;
    end else begin
      irq_stat_r <= (irq_stat_r & ~(wr_stat ? reg_wdata[FCU_IRQ_W-1:0] : '0)) | irq_ev;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      irq_mask_r <= '0;
    end else if (wr_mask) begin
      irq_mask_r <= reg_wdata[FCU_IRQ_W-1:0];
    end
  end

  assign irq = |(irq_stat_r & irq_mask_r);

  // unmapped reads return zero
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      reg_rdata <= 32'h0;
    end else if (reg_rd) begin
      case (reg_addr)
        FCU_OFS_CTRL:     reg_rdata <= ctrl_r;
        FCU_OFS_FP_STATUS_CONTROL_REG:    reg_rdata <= fp_status_control_reg_r;
        FCU_OFS_CR:       reg_rdata <= cr_r;
        FCU_OFS_IRQ_STAT: reg_rdata <= 32'(irq_stat_r);
        FCU_OFS_IRQ_MASK: reg_rdata <= 32'(irq_mask_r);
        default:          reg_rdata <= 32'h0;
      endcase
    end else begin
      reg_rdata <= 32'h0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  logic conv_hit;
  assign conv_hit = issue_valid && instr[31:26] == FCU_OPC_FP && instr[20:16] == FCU_FIELD_ZERO &&
                    (instr[10:1] == FCU_XO_FROM_INT || instr[10:1] == FCU_XO_TO_INT);

  property p_from_int_one;
    issue_valid && instr[31:26] == FCU_OPC_FP && instr[10:1] == FCU_XO_FROM_INT &&
    instr[20:16] == FCU_FIELD_ZERO && mode64 && second_source_fp_reg == 64'h1
    |=> res_valid && res_data == 64'h3ff0_0000_0000_0000 && fp_status_control_reg_r[FCU_B_RESULT_CLASS_FIELD +: 5] == FCU_RESULT_CLASS_FIELD_PNORM;
  endproperty
  a_from_int_one: assert property (p_from_int_one) else $error("int one not converted");

  property p_illegal32;
    conv_hit && !mode64 |=> illegal_instr && !res_valid && !cr_we;
  endproperty
  a_illegal32: assert property (p_illegal32) else $error("conversion not trapped");

  property p_no_record;
    conv_hit && mode64 && !instr[0] |=> !cr_we && ($stable(cr_r) || $past(wr_cr));
  endproperty
  a_no_record: assert property (p_no_record) else $error("cr changed without record bit");

  property p_record;
    conv_hit && mode64 && instr[0] |=> cr_we && cr_field_select == FCU_CR_FIELD_CONV &&
      cr_field_data == {fp_status_control_reg_r[FCU_B_FX], fp_status_control_reg_r[FCU_B_FEX], fp_status_control_reg_r[FCU_B_VX], fp_status_control_reg_r[FCU_B_OX]};
  endproperty
  a_record: assert property (p_record) else $error("field 1 summary wrong");

  sequence s_cmp_issue;
    op == FCU_OP_CMP_ORD || op == FCU_OP_CMP_UNORD;
  endsequence
  sequence s_cmp_done(logic [2:0] sel);
    cr_we && cr_field_select == sel && cr_field_data == fp_status_control_reg_r[FCU_B_RESULT_CLASS_FIELD +: 4];
  endsequence

  property p_cmp_cr;
    logic [2:0] s;
    (s_cmp_issue, s = instr[25:23]) |=> s_cmp_done(s);
  endproperty
  a_cmp_cr: assert property (p_cmp_cr) else $error("compare code not copied");

  property p_nan_unord;
    s_cmp_issue ##0 (cm_a_nan || cm_b_nan) |=> cr_field_data == FCU_CC_UN;
  endproperty
  a_nan_unord: assert property (p_nan_unord) else $error("nan not unordered");

  property p_snan_flag;
    (op == FCU_OP_CMP_ORD || op == FCU_OP_CMP_UNORD) && cm_snan |=> fp_status_control_reg_r[FCU_B_SIGNALING_NAN_INVALID] && fp_status_control_reg_r[FCU_B_FX];
  endproperty
  a_snan_flag: assert property (p_snan_flag) else $error("snan flag missing");

  property p_ord_qnan;
    op == FCU_OP_CMP_ORD && cm_qnan |=> fp_status_control_reg_r[FCU_B_INVALID_COMPARE_FLAG] && fp_status_control_reg_r[FCU_B_VX];
  endproperty
  a_ord_qnan: assert property (p_ord_qnan) else $error("invalid compare not set");

  property p_unord_novc;
    op == FCU_OP_CMP_UNORD && !fp_status_control_reg_r[FCU_B_INVALID_COMPARE_FLAG] && !wr_fp_status_control_reg |=> !fp_status_control_reg_r[FCU_B_INVALID_COMPARE_FLAG];
  endproperty
  a_unord_novc: assert property (p_unord_novc) else $error("unordered set invalid compare");

  property p_saturate;
    op == FCU_OP_TO_INT && !second_source_fp_reg[63] && second_source_fp_reg[62:52] >= FCU_EXP_INT_TOP &&
    !fcu_is_nan(second_source_fp_reg)
    |=> res_data == FCU_INT_MAX && fp_status_control_reg_r[FCU_B_INVALID_CONVERT_FLAG] && !fp_status_control_reg_r[FCU_B_FI];
  endproperty
  a_saturate: assert property (p_saturate) else $error("no saturation");
endmodule : fcu_unit
`default_nettype wire

/* verif/fcu_issue_model.sv */
`timescale 1ns/1ps
`default_nettype none
module fcu_issue_model (
  input  wire logic        clk,
  output logic             issue_valid,
  output logic [31:0]      instr,
  output logic [63:0]      first_source_fp_reg,
  output logic [63:0]      second_source_fp_reg
);
  initial begin
    issue_valid          = 1'b0;
    instr                = 32'h0000_0000;
    first_source_fp_reg  = 64'h0;
    second_source_fp_reg = 64'h0;
  end
  // idle operands inverted so a stale value can never pass for a live one
  task automatic issue(input logic [31:0] ins, input logic [63:0] a, input logic [63:0] b);
    @(posedge clk);
    issue_valid          <= 1'b1;
    instr                <= ins;
    first_source_fp_reg  <= a;
    second_source_fp_reg <= b;
    @(posedge clk);
    issue_valid          <= 1'b0;
    instr                <= ~ins;
    first_source_fp_reg  <= ~a;
    second_source_fp_reg <= ~b;
  endtask : issue
endmodule : fcu_issue_model
`default_nettype wire

/* verif/fcu_unit_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module fcu_unit_tb
  import fcu_pkg::*;
;
  localparam logic [63:0] QN  = 64'h7ff8_0000_0000_0000;
  localparam logic [63:0] SN  = 64'h7ff0_0000_0000_0001;
  localparam logic [63:0] ONE = 64'h3ff0_0000_0000_0000;
  logic        clk;
  logic        reset_n;
  logic        issue_valid;
  logic [31:0] instr;
  logic [63:0] op_a;
  logic [63:0] op_b;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic        res_valid;
  logic [63:0] res_data;
  logic [4:0]  target_fp_reg;
  logic        cr_we;
  logic [2:0]  cr_field_select;
  logic [3:0]  cr_field_data;
  logic        illegal_instr;
  logic        irq;
  int          bad_count;
  int          checks;
  fcu_issue_model u_issue (.clk(clk), .issue_valid(issue_valid), .instr(instr),
    .first_source_fp_reg(op_a), .second_source_fp_reg(op_b));
  fcu_unit u_dut (.clk(clk), .reset_n(reset_n), .issue_valid(issue_valid), .instr(instr),
    .first_source_fp_reg(op_a), .second_source_fp_reg(op_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .res_valid(res_valid), .res_data(res_data),
    .target_fp_reg(target_fp_reg), .cr_we(cr_we), .cr_field_select(cr_field_select),
    .cr_field_data(cr_field_data), .illegal_instr(illegal_instr), .irq(irq));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk({32'h0, reg_rdata}, {32'h0, e});
  endtask : rd
  function automatic logic [31:0] op(input logic [9:0] xo, input logic [4:0] t, input logic rc);
    return {FCU_OPC_FP, t, 10'h000, xo, rc};
  endfunction : op
  // cr packs {written, field, value}; conversions carry xo bit 9, compares never
  task automatic run(input logic [31:0] ins, input logic [63:0] a, input logic [63:0] b, input logic [31:0] ctl,
                     input logic [63:0] res, input logic [31:0] fs, input logic [7:0] cr);
    wr(FCU_OFS_FP_STATUS_CONTROL_REG, ctl);
    u_issue.issue(ins, a, b);
    #1;
    chk({63'h0, res_valid}, {63'h0, ins[10]});
    if (ins[10]) begin
      chk(res_data, res);
      chk({59'h0, target_fp_reg}, {59'h0, ins[25:21]});
    end
    chk({56'h0, cr_we, cr_we ? {cr_field_select, cr_field_data} : 7'h00}, {56'h0, cr});
    rd(FCU_OFS_FP_STATUS_CONTROL_REG, fs);
  endtask : run
  task automatic t_reset;
    rd(FCU_OFS_CTRL, FCU_CTRL_RST);
    rd(FCU_OFS_FP_STATUS_CONTROL_REG, 32'h0000_0000);
    rd(FCU_OFS_CR, 32'h0000_0000);
    rd(FCU_OFS_IRQ_MASK, 32'h0000_0000);
    rd(8'h14, 32'h0000_0000);
    $display("reset test done");
  endtask : t_reset
  task automatic t_cmp;
    run(op(FCU_XO_CMP_UNORD, 5'h18, 1'b0), 64'h400c_0000_0000_0000, 64'hc053_4000_0000_0000,
        0, 0, 32'h4000, 8'he4);
    rd(FCU_OFS_CR, 32'h0000_0040);
    run(op(FCU_XO_CMP_ORD, 5'h0c, 1'b0), ONE, 64'h400c_0000_0000_0000, 0, 0, 32'h8000, 8'hb8);
    run(op(FCU_XO_CMP_ORD, 5'h0c, 1'b0), 64'h0, 64'h8000_0000_0000_0000, 0, 0, 32'h2000, 8'hb2);
    run(op(FCU_XO_CMP_ORD, 5'h18, 1'b0), QN, ONE, 0, 0, 32'ha008_1000, 8'he1);
    run(op(FCU_XO_CMP_UNORD, 5'h18, 1'b0), ONE, QN, 0, 0, 32'h0000_1000, 8'he1);
    run(op(FCU_XO_CMP_UNORD, 5'h18, 1'b0), ONE, SN, 0, 0, 32'ha100_1000, 8'he1);
    run(op(FCU_XO_CMP_ORD, 5'h18, 1'b0), SN, ONE, 0, 0, 32'ha108_1000, 8'he1);
    run(op(FCU_XO_CMP_ORD, 5'h18, 1'b0), SN, ONE, 32'h80, 0, 32'he100_1080, 8'he1);
    $display("compare test done");
  endtask : t_cmp
  task automatic t_from_int;
    run(op(FCU_XO_FROM_INT, 5'h05, 1'b1), 0, 64'h1, 0, ONE, 32'h4000, 8'h90);
    run(op(FCU_XO_FROM_INT, 5'h05, 1'b1), 0, 64'h0020_0000_0000_0001, 0, 64'h4340_0000_0000_0000,
        32'h8202_4000, 8'h98);
    run(op(FCU_XO_FROM_INT, 5'h05, 1'b1), 0, 64'h0020_0000_0000_0001, 2, 64'h4340_0000_0000_0001,
        32'h8206_4002, 8'h98);
    run(op(FCU_XO_FROM_INT, 5'h05, 1'b1), 0, 64'hffdf_ffff_ffff_ffff, 3, 64'hc340_0000_0000_0001,
        32'h8206_8003, 8'h98);
    run(op(FCU_XO_FROM_INT, 5'h09, 1'b0), 0, '1, 0, 64'hbff0_0000_0000_0000, 32'h8000, 8'h00);
    run(op(FCU_XO_FROM_INT, 5'h09, 1'b0), 0, 64'h0, 0, 64'h0, 32'h2000, 8'h00);
    $display("from-int test done");
  endtask : t_from_int
  task automatic t_to_int;
    run(op(FCU_XO_TO_INT, 5'h07, 1'b1), 0, 64'h3ff8_0000_0000_0000, 0, 64'h2, 32'h8206_0000, 8'h98);
    run(op(FCU_XO_TO_INT, 5'h07, 1'b1), 0, 64'h3ff8_0000_0000_0000, 1, 64'h1, 32'h8202_0001, 8'h98);
    run(op(FCU_XO_TO_INT, 5'h07, 1'b1), 0, 64'h47e0_0000_0000_0000, 0, FCU_INT_MAX, 32'ha000_0100, 8'h9a);
    run(op(FCU_XO_TO_INT, 5'h07, 1'b1), 0, 64'hfff0_0000_0000_0000, 0, FCU_INT_MIN, 32'ha000_0100, 8'h9a);
    $display("to-int test done");
  endtask : t_to_int
  task automatic t_illegal;
    rd(FCU_OFS_IRQ_STAT, 32'he);
    wr(FCU_OFS_IRQ_STAT, 32'hf);
    wr(FCU_OFS_IRQ_MASK, 32'h1);
    wr(FCU_OFS_FP_STATUS_CONTROL_REG, 32'h0);
    wr(FCU_OFS_CTRL, 32'h0);
    u_issue.issue(op(FCU_XO_FROM_INT, 5'h03, 1'b1), 0, 64'h5);
    #1;
    chk({illegal_instr, res_valid, cr_we}, 3'b100);
    rd(FCU_OFS_IRQ_STAT, 32'h1);
    rd(FCU_OFS_FP_STATUS_CONTROL_REG, 32'h0);
    chk(irq, 1'b1);
    wr(FCU_OFS_IRQ_MASK, 32'h0);
    #1;
    chk(irq, 1'b0);
    wr(FCU_OFS_IRQ_MASK, 32'h1);
    wr(FCU_OFS_IRQ_STAT, 32'h1);
    #1;
    chk(irq, 1'b0);
    wr(FCU_OFS_CTRL, 32'h1);
    $display("illegal test done");
  endtask : t_illegal
  task automatic summarize;
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : summarize
  initial begin
    repeat (4000) @(posedge clk);
    bad_count++;
    summarize();
  end
  initial begin
    bad_count = 0;
    checks    = 0;
    reset_n   = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 32'h0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    t_reset();
    t_cmp();
    t_from_int();
    t_to_int();
    t_illegal();
    summarize();
  end
endmodule : fcu_unit_tb
`default_nettype wire
